//--- inc/acm_pkg.sv
// Purpose: Shared constants and types for the ASI channel monitor and alarm block
// Assumes: 200 MHz mclk, byte-addressed Avalon-MM register window of 256 bytes
// Notes:   Two-bit status codes follow the management object encodings
package acm_pkg;
    // Channel count and rate width (rates are in kbit/s)
    localparam int NCH = 4;
    localparam int RATE_W = 20;
    localparam logic [RATE_W-1:0] LIMIT_KBPS = 20'h24220;  // 148000 kbit/s
    localparam logic [RATE_W-1:0] CEIL_RST = 20'h09088;    // 37000 kbit/s
    // Two-bit codes
    localparam logic [1:0] CODE_OFF = 2'h1;
    localparam logic [1:0] CODE_ON = 2'h2;
    localparam logic [1:0] ALM_NONE = 2'h1;
    localparam logic [1:0] ALM_MAJOR = 2'h2;
    localparam logic [1:0] ALM_MINOR = 2'h3;
    localparam logic [1:0] CODING_CMI = 2'h1;
    localparam logic [1:0] CODING_NRZ = 2'h3;
    localparam logic [1:0] PKT_188 = 2'h1;
    localparam logic [1:0] PKT_204 = 2'h2;
    localparam logic [31:0] RESET_CMD = 32'h00000002;
    // Global register byte offsets
    localparam logic [7:0] OFF_SUMMARY = 8'h00;
    localparam logic [7:0] OFF_CAP = 8'h04;
    localparam logic [7:0] OFF_CODING = 8'h08;
    localparam logic [7:0] OFF_REV = 8'h0C;
    localparam logic [7:0] OFF_RESET = 8'h10;
    localparam logic [7:0] OFF_SUM_EV = 8'h14;
    localparam logic [7:0] OFF_OVR_EV = 8'h18;
    localparam logic [7:0] OFF_PRES_EV = 8'h1C;
    localparam logic [7:0] OFF_UPTIME = 8'h20;
    // Per-channel window: base 0x40, 0x20 bytes per channel
    localparam logic [7:0] CH_BASE = 8'h40;
    localparam logic [2:0] CH_FIRST = 3'h2;
    localparam logic [2:0] SUB_STATUS = 3'h0;
    localparam logic [2:0] SUB_ON = 3'h1;
    localparam logic [2:0] SUB_RATE = 3'h2;
    localparam logic [2:0] SUB_CEIL = 3'h3;
    // Sub-words 4 to 7 hold the channel label
    localparam logic [31:0] LABEL_LAST_MASK = 32'h00FFFFFF;
    // Field positions
    localparam int ST_SEEN_LSB = 0;
    localparam int ST_PKT_LSB = 8;
    localparam int ST_OVR_LSB = 16;
    localparam int REV_MAJ_LSB = 8;
    // Timing
    localparam int CLK_NS = 5;
    localparam int WINDOW_NS = 1000000;       // Rate measuring window, 1 ms
    localparam int WINDOW_CYC = WINDOW_NS / CLK_NS;
    localparam int BLINK_NS = 250000000;      // Indicator half period, 250 ms
    localparam int BLINK_CYC = BLINK_NS / CLK_NS;

    // Per-channel inputs from the datapath
    typedef struct packed {
        logic seen;       // Valid ASI detected
        logic pkt204;     // 204-byte packets detected
        logic byte_tick;  // One payload byte received
    } acm_chan_in_type;

    typedef enum logic [1:0] {ACM_IDLE = 2'b01, ACM_ACK = 2'b10} acm_bus_state_type;
endpackage

//--- core/acm_mgmt.sv
// Purpose: Channel monitoring, rate capping, alarm and event logic, Avalon-MM slave
// Assumes: Inputs synchronous to mclk; one byte_tick per received payload byte
`timescale 1ns/100ps
module acm_mgmt #(
    parameter int NCH = acm_pkg::NCH,                 // 1 to 4 channels
    parameter int WINDOW_CYC = acm_pkg::WINDOW_CYC,   // Rate window in cycles
    parameter int BLINK_CYC = acm_pkg::BLINK_CYC,     // Blink half period
    parameter logic [7:0] REV_MAJOR = 8'h01,          // Arbitrary value
    parameter logic [7:0] REV_MINOR = 8'h00           // Arbitrary value
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire acm_pkg::acm_chan_in_type [NCH-1:0] chan_in,
    input wire logic coding_select_switch,
    output logic [NCH-1:0] channel_on_out,
    output logic [NCH-1:0] led,
    output logic [NCH-1:0] event_presence,
    output logic [NCH-1:0] event_overrate,
    output logic event_summary,
    output logic system_reset_req
);
    localparam int RW = acm_pkg::RATE_W;
    localparam int SW = RW + 3;            // Sum width, no overflow for 4 channels
    localparam int WCW = $clog2(WINDOW_CYC + 1);
    localparam int BCW = $clog2(BLINK_CYC + 1);

    // Byte-enable merge of write data over the current register value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Sum of a set of per-channel rates
    function automatic logic [SW-1:0] sum_rates(input logic [NCH-1:0][RW-1:0] v);
        logic [SW-1:0] s;
        s = '0;
        for (int i = 0; i < NCH; i++) begin
            s = s + SW'(v[i]);
        end
        return s;
    endfunction

    // Two-bit enable codes accept only 1 or 2
    function automatic logic code_ok(input logic [1:0] c);
        return (c == acm_pkg::CODE_OFF) || (c == acm_pkg::CODE_ON);
    endfunction

    acm_pkg::acm_bus_state_type bus_state;
    logic [1:0] rate_cap_master_enable;            // Global capping code
    logic [1:0] summary_event_enable;
    logic [1:0] overrate_event_enable;
    logic [1:0] presence_event_enable;
    logic [1:0] channel_on [NCH];                  // Per-channel enable code
    logic [NCH-1:0][RW-1:0] channel_rate_ceiling;
    logic [NCH-1:0][RW-1:0] channel_measured_rate;
    logic [RW-4:0] byte_cnt [NCH];                 // Bytes seen in current window
    logic [31:0] channel_label [NCH][4];
    logic [WCW-1:0] win_cnt;
    logic [BCW-1:0] blink_cnt;
    logic blink_phase;
    logic [31:0] uptime;                           // Counts whole windows
    logic [1:0] alarm_q;                           // Summary code as reported
    logic [NCH-1:0] overrate_q;
    logic [NCH-1:0] seen_q;
    logic [31:0] rd_value;

    // Decode of the addressed register
    wire [7:0] wa = {avs_address[7:2], 2'b00};
    wire [2:0] ch_raw = avs_address[7:5] - acm_pkg::CH_FIRST;
    wire [1:0] ch = ch_raw[1:0];
    wire [2:0] sub = avs_address[4:2];
    wire in_chan = (avs_address >= acm_pkg::CH_BASE) && (32'(ch_raw) < NCH);
    wire take = (avs_read || avs_write) && (bus_state == acm_pkg::ACM_IDLE);
    wire wr = avs_write && (bus_state == acm_pkg::ACM_ACK);
    wire [31:0] wdata = merge(rd_value, avs_writedata, avs_byteenable);
    wire wr_glob = wr && !in_chan && (avs_address < acm_pkg::CH_BASE);
    wire wr_ch = wr && in_chan;
    wire soft_rst = wr_glob && (wa == acm_pkg::OFF_RESET)
                    && (wdata == acm_pkg::RESET_CMD);
    wire win_end = (32'(win_cnt) == WINDOW_CYC - 1);

    // Monitor conditions
    wire [NCH-1:0] seen;
    wire [NCH-1:0] overrate;
    wire [NCH-1:0] flash;
    wire [SW-1:0] total_rate = sum_rates(channel_measured_rate);
    wire [SW-1:0] total_ceil = sum_rates(channel_rate_ceiling);
    wire cap_on = (rate_cap_master_enable == acm_pkg::CODE_ON);
    wire major = total_rate > SW'(acm_pkg::LIMIT_KBPS);
    wire minor = ~|seen;
    // Major takes precedence when both hold
    wire [1:0] alarm_code = major ? acm_pkg::ALM_MAJOR :
                            minor ? acm_pkg::ALM_MINOR : acm_pkg::ALM_NONE;
    // A new ceiling must keep the summed ceilings within the line limit
    wire [SW-1:0] ceil_try = total_ceil - SW'(channel_rate_ceiling[ch]) + SW'(wdata[RW-1:0]);
    wire ceil_ok = (wdata[31:RW] == '0) && (ceil_try <= SW'(acm_pkg::LIMIT_KBPS));

    for (genvar i = 0; i < NCH; i++) begin : g_mon
        assign seen[i] = chan_in[i].seen;
        // Flag applies only while capping is on
        assign overrate[i] = cap_on
                             && (channel_measured_rate[i] > channel_rate_ceiling[i]);
        // Disabled with signal present, or over its ceiling
        assign flash[i] = (seen[i] && channel_on[i] != acm_pkg::CODE_ON) || overrate_q[i];
    end

    // Read selection; status presence and overrate are registered, packet length is live from chan_in
    always_comb begin
        rd_value = '0;
        if (in_chan) begin
            unique case (sub)
                acm_pkg::SUB_STATUS: begin
                    rd_value[acm_pkg::ST_SEEN_LSB +: 2] = seen_q[ch] ? acm_pkg::CODE_ON
                                                                     : acm_pkg::CODE_OFF;
                    rd_value[acm_pkg::ST_PKT_LSB +: 2] = chan_in[ch].pkt204 ? acm_pkg::PKT_204
                                                                            : acm_pkg::PKT_188;
                    rd_value[acm_pkg::ST_OVR_LSB +: 2] = overrate_q[ch] ? acm_pkg::CODE_ON
                                                                        : acm_pkg::CODE_OFF;
                end
                acm_pkg::SUB_ON: rd_value[1:0] = channel_on[ch];
                acm_pkg::SUB_RATE: rd_value[RW-1:0] = channel_measured_rate[ch];
                acm_pkg::SUB_CEIL: rd_value[RW-1:0] = channel_rate_ceiling[ch];
                default: rd_value = channel_label[ch][sub[1:0]];
            endcase
        end else begin
            unique case (wa)
                acm_pkg::OFF_SUMMARY: rd_value[1:0] = alarm_q;
                acm_pkg::OFF_CAP: rd_value[1:0] = rate_cap_master_enable;
                acm_pkg::OFF_CODING: rd_value[1:0] = coding_select_switch ? acm_pkg::CODING_NRZ
                                                                          : acm_pkg::CODING_CMI;
                acm_pkg::OFF_REV: rd_value[15:0] = {REV_MAJOR, REV_MINOR};
                acm_pkg::OFF_SUM_EV: rd_value[1:0] = summary_event_enable;
                acm_pkg::OFF_OVR_EV: rd_value[1:0] = overrate_event_enable;
                acm_pkg::OFF_PRES_EV: rd_value[1:0] = presence_event_enable;
                acm_pkg::OFF_UPTIME: rd_value = uptime;
                default: rd_value = '0;  // Reset control and unmapped read as zero
            endcase
        end
    end

    // Bus handshake: one wait cycle, answer in the next
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_state <= acm_pkg::ACM_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
        end else begin
            bus_state <= take ? acm_pkg::ACM_ACK : acm_pkg::ACM_IDLE;
            avs_waitrequest <= !take;
            if (take && avs_read) begin
                avs_readdata <= rd_value;
            end
        end
    end

    // Global control registers; the reset command restores defaults
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rate_cap_master_enable <= acm_pkg::CODE_OFF;
            summary_event_enable <= acm_pkg::CODE_OFF;
            overrate_event_enable <= acm_pkg::CODE_OFF;
            presence_event_enable <= acm_pkg::CODE_OFF;
        end else if (soft_rst) begin
            rate_cap_master_enable <= acm_pkg::CODE_OFF;
            summary_event_enable <= acm_pkg::CODE_OFF;
            overrate_event_enable <= acm_pkg::CODE_OFF;
            presence_event_enable <= acm_pkg::CODE_OFF;
        end else if (wr_glob && code_ok(wdata[1:0])) begin
            // Codes other than 1 and 2 are ignored
            if (wa == acm_pkg::OFF_CAP) begin
                rate_cap_master_enable <= wdata[1:0];
            end
            if (wa == acm_pkg::OFF_SUM_EV) begin
                summary_event_enable <= wdata[1:0];
            end
            if (wa == acm_pkg::OFF_OVR_EV) begin
                overrate_event_enable <= wdata[1:0];
            end
            if (wa == acm_pkg::OFF_PRES_EV) begin
                presence_event_enable <= wdata[1:0];
            end
        end
    end

    // Per-channel control: enable, ceiling, label
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NCH; i++) begin
                channel_on[i] <= acm_pkg::CODE_ON;
                channel_rate_ceiling[i] <= acm_pkg::CEIL_RST;
                for (int w = 0; w < 4; w++) begin
                    channel_label[i][w] <= '0;
                end
            end
        end else if (soft_rst) begin
            for (int i = 0; i < NCH; i++) begin
                channel_on[i] <= acm_pkg::CODE_ON;
                channel_rate_ceiling[i] <= acm_pkg::CEIL_RST;
            end
        end else if (wr_ch) begin
            if (sub == acm_pkg::SUB_ON && code_ok(wdata[1:0])) begin
                channel_on[ch] <= wdata[1:0];
            end
            if (sub == acm_pkg::SUB_CEIL && ceil_ok) begin
                channel_rate_ceiling[ch] <= wdata[RW-1:0];
            end
            if (sub[2]) begin
                // Last word keeps its top byte zero: fifteen bytes in all
                channel_label[ch][sub[1:0]] <= (sub[1:0] == 2'h3)
                    ? (wdata & acm_pkg::LABEL_LAST_MASK) : wdata;
            end
        end
    end

    // Rate window, byte counting and uptime
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            win_cnt <= '0;
            uptime <= '0;
            for (int i = 0; i < NCH; i++) begin
                byte_cnt[i] <= '0;
                channel_measured_rate[i] <= '0;
            end
        end else begin
            win_cnt <= win_end ? '0 : win_cnt + 1'b1;
            if (soft_rst) begin
                uptime <= '0;
            end else if (win_end) begin
                uptime <= uptime + 1'b1;
            end
            for (int i = 0; i < NCH; i++) begin
                if (win_end) begin
                    // Bytes per 1 ms times eight is kbit/s
                    channel_measured_rate[i] <= {byte_cnt[i], 3'b000};
                    byte_cnt[i] <= RW'(chan_in[i].byte_tick) > 0 ? (RW-3)'(1) : '0;
                end else begin
                    byte_cnt[i] <= byte_cnt[i] + (RW-3)'(chan_in[i].byte_tick);
                end
            end
        end
    end

    // Alarm state, edge history and event pulses
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_q <= acm_pkg::ALM_NONE;
            overrate_q <= '0;
            seen_q <= '0;
            event_summary <= 1'b0;
            event_overrate <= '0;
            event_presence <= '0;
            system_reset_req <= 1'b0;
        end else begin
            alarm_q <= alarm_code;
            overrate_q <= overrate;
            seen_q <= seen;
            event_summary <= (summary_event_enable == acm_pkg::CODE_ON)
                             && (alarm_code != alarm_q);
            event_overrate <= (overrate_event_enable == acm_pkg::CODE_ON)
                              ? (overrate ^ overrate_q) : '0;
            event_presence <= (presence_event_enable == acm_pkg::CODE_ON)
                              ? (seen ^ seen_q) : '0;
            system_reset_req <= soft_rst;
        end
    end

    // Indicators: steady when present, flashing on disable or overrate
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            blink_cnt <= '0;
            blink_phase <= 1'b0;
            led <= '0;
            channel_on_out <= '0;
        end else begin
            blink_cnt <= (32'(blink_cnt) == BLINK_CYC - 1) ? '0 : blink_cnt + 1'b1;
            if (32'(blink_cnt) == BLINK_CYC - 1) begin
                blink_phase <= !blink_phase;
            end
            for (int i = 0; i < NCH; i++) begin
                led[i] <= seen_q[i] && (!flash[i] || blink_phase);
                channel_on_out[i] <= (channel_on[i] == acm_pkg::CODE_ON);
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    major_code_a: assert property (major |=> alarm_q == acm_pkg::ALM_MAJOR)
        else $error("major condition not reported as code 2");
    minor_code_a: assert property (!major && minor |=> alarm_q == acm_pkg::ALM_MINOR)
        else $error("no-input condition not reported as code 3");
    none_code_a: assert property (!major && !minor |=> alarm_q == acm_pkg::ALM_NONE)
        else $error("quiet state not reported as code 1");
    ceil_sum_a: assert property (total_ceil <= SW'(acm_pkg::LIMIT_KBPS))
        else $error("summed ceilings exceed line limit");
    reset_read_a: assert property (take && avs_read && !in_chan && wa == acm_pkg::OFF_RESET
        |=> avs_readdata == '0 && !avs_waitrequest)
        else $error("reset control did not read zero");
    soft_reset_a: assert property (soft_rst |=> system_reset_req && uptime == '0)
        else $error("reset command did not pulse or clear uptime");
    cap_off_a: assert property (!cap_on ##1 !cap_on |=> overrate_q == '0)
        else $error("overrate flag set with capping off");
    pres_event_a: assert property (presence_event_enable == acm_pkg::CODE_ON
        && seen != seen_q |=> event_presence == $past(seen ^ seen_q))
        else $error("presence edge produced no event");
    sum_event_a: assert property (summary_event_enable == acm_pkg::CODE_ON
        && alarm_code != alarm_q |=> event_summary)
        else $error("alarm change produced no event");
    bus_answer_a: assert property (take |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("slave did not answer in one cycle");

    soft_reset_c: cover property (soft_rst);
    ceil_reject_c: cover property (wr_ch && sub == acm_pkg::SUB_CEIL && !ceil_ok);
    major_c: cover property (major ##1 event_summary);
    over_c: cover property (cap_on && |overrate ##1 |event_overrate);
endmodule // acm_mgmt

//--- bench/acm_chan_src.sv
// Purpose: Behavioural ASI channel source feeding the monitor inputs
// Assumes: One byte every per cycles on each channel that has signal
// Notes:   per of zero means no payload; ticks stop while signal absent
`timescale 1ns/100ps
module acm_chan_src (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [3:0] seen,
    input wire logic [3:0] pkt,
    input wire logic [7:0] per,
    output acm_pkg::acm_chan_in_type [3:0] chan_in
);
    logic [7:0] cnt; // Shared byte spacing counter
    wire tick = (per != 8'h00) && (cnt == per - 8'h01);
    // Counter parks at zero when idle so a new rate starts cleanly
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 8'h00;
        end else begin
            cnt <= (tick || per == 8'h00) ? 8'h00 : cnt + 8'h01;
        end
    end
    // No bytes leave a channel without signal
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            chan_in[i] = '{seen: seen[i], pkt204: pkt[i], byte_tick: tick & seen[i]};
        end
    end
endmodule // acm_chan_src

//--- bench/asi_channel_monitor_alarm_mgmt_bench.sv
// Purpose: Self-checking bench for the channel monitor register block
// Assumes: Rate window of WIN cycles, so each rate reads 8 x bytes in window
// Notes:   One phase runs all channels flat out to push the sum past the limit
`timescale 1ns/100ps
module asi_channel_monitor_alarm_mgmt_bench;
    logic mclk, arst_n, avs_read, avs_write, sw, ev_s, sys_rst, avs_waitrequest, prev;
    logic [7:0] avs_address, per;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] seen, pkt, on_out, led, ev_p, ev_o;
    logic [31:0] lab [4];
    acm_pkg::acm_chan_in_type [3:0] chan_in;
    int err_count = 0, num_checks = 0, cyc = 0, n_s = 0, n_p = 0, n_o = 0, n_r = 0, tog, ns;
    // Window long enough that four full-rate channels exceed the line limit
    localparam int WIN = 4800;
    localparam int RATE4 = 8 * WIN / 4; // Expected rate at one byte every four cycles
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    acm_chan_src u_acm_chan_src (.mclk(mclk), .arst_n(arst_n), .seen(seen), .pkt(pkt),
        .per(per), .chan_in(chan_in));
    acm_mgmt #(.WINDOW_CYC(WIN), .BLINK_CYC(8)) u_acm_mgmt (.mclk(mclk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .chan_in(chan_in), .coding_select_switch(sw),
        .channel_on_out(on_out), .led(led), .event_presence(ev_p), .event_overrate(ev_o),
        .event_summary(ev_s), .system_reset_req(sys_rst));
    // Pulse counters and the hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (arst_n) begin
            n_s <= n_s + ev_s;
            n_p <= n_p + $countones(ev_p);
            n_o <= n_o + $countones(ev_o);
            n_r <= n_r + sys_rst;
        end
        if (cyc == 60000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One Avalon access; request held until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        cmp(q, e);
    endtask
    function automatic logic [7:0] ca(input int n, input logic [2:0] sub);
        return acm_pkg::CH_BASE + 8'(n * 32) + {3'h0, sub, 2'h0};
    endfunction
    // Expected status word from presence, length and overrate codes
    function automatic logic [31:0] st(input logic s, input logic p, input logic [1:0] o);
        return ({30'h0, s ? acm_pkg::CODE_ON : acm_pkg::CODE_OFF} << acm_pkg::ST_SEEN_LSB)
            | ({30'h0, p ? acm_pkg::PKT_204 : acm_pkg::PKT_188} << acm_pkg::ST_PKT_LSB)
            | ({30'h0, o} << acm_pkg::ST_OVR_LSB);
    endfunction
    initial begin
        void'($urandom(32'hc810b628));
        {arst_n, avs_read, avs_write, sw, seen, pkt, per, avs_address, avs_writedata} = '0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        sw <= 1'($urandom);
        chk(acm_pkg::OFF_CAP, 32'(acm_pkg::CODE_OFF));
        chk(acm_pkg::OFF_RESET, 32'h0);
        chk(acm_pkg::OFF_SUMMARY, 32'(acm_pkg::ALM_MINOR));
        chk(acm_pkg::OFF_REV, 32'h00000100);
        chk(8'h24, 32'h0);
        chk(acm_pkg::OFF_CODING, 32'(sw ? acm_pkg::CODING_NRZ : acm_pkg::CODING_CMI));
        chk(ca(0, acm_pkg::SUB_ON), 32'(acm_pkg::CODE_ON));
        acc(1'b1, acm_pkg::OFF_SUM_EV, 32'h2);
        acc(1'b1, acm_pkg::OFF_OVR_EV, 32'h2);
        acc(1'b1, acm_pkg::OFF_PRES_EV, 32'h2);
        // Channels 0 and 1 always carry signal; the rest at random
        seen <= 4'($urandom) | 4'h3;
        pkt <= 4'($urandom);
        per <= 8'h04;
        // First window is partial; the second is full
        repeat (2 * WIN + 20) @(posedge mclk);
        ns = $countones(seen);
        cmp(n_s, 1);
        cmp(n_p, ns);
        chk(acm_pkg::OFF_SUMMARY, 32'(acm_pkg::ALM_NONE));
        for (int i = 0; i < 4; i++) begin
            chk(ca(i, acm_pkg::SUB_STATUS), st(seen[i], pkt[i], 2'h1));
            chk(ca(i, acm_pkg::SUB_RATE), seen[i] ? 32'(RATE4) : 32'h0);
        end
        // Capping on with ceiling under the measured rate
        acc(1'b1, acm_pkg::OFF_CAP, 32'(acm_pkg::CODE_ON));
        acc(1'b1, ca(0, acm_pkg::SUB_CEIL), 32'd100);
        repeat (200) @(posedge mclk);
        chk(ca(0, acm_pkg::SUB_STATUS), st(1'b1, pkt[0], 2'h2));
        cmp(n_o, 1);
        // Sum lands exactly on the limit, then one more is refused
        acc(1'b1, ca(1, acm_pkg::SUB_CEIL), 32'd73900);
        chk(ca(1, acm_pkg::SUB_CEIL), 32'd73900);
        acc(1'b1, ca(2, acm_pkg::SUB_CEIL), 32'd37001);
        chk(ca(2, acm_pkg::SUB_CEIL), 32'd37000);
        // Sum sits on the limit, so a lower ceiling must go in first
        acc(1'b1, ca(2, acm_pkg::SUB_CEIL), 32'd27000);
        chk(ca(2, acm_pkg::SUB_CEIL), 32'd27000);
        // Ceiling equal to the measured rate clears the flag
        acc(1'b1, ca(0, acm_pkg::SUB_CEIL), 32'(RATE4));
        repeat (200) @(posedge mclk);
        cmp(n_o, 2);
        chk(ca(0, acm_pkg::SUB_STATUS), st(1'b1, pkt[0], 2'h1));
        // Bad enable code ignored, then disable channel 1
        acc(1'b1, ca(1, acm_pkg::SUB_ON), 32'h3);
        chk(ca(1, acm_pkg::SUB_ON), 32'(acm_pkg::CODE_ON));
        acc(1'b1, ca(1, acm_pkg::SUB_ON), 32'(acm_pkg::CODE_OFF));
        repeat (4) @(posedge mclk);
        cmp(32'(on_out), 32'hD);
        tog = 0;
        prev = led[1];
        repeat (32) begin
            @(posedge mclk);
            tog += (led[1] !== prev);
            prev = led[1];
        end
        cmp(tog, 4);
        for (int j = 0; j < 4; j++) begin
            lab[j] = $urandom;
            acc(1'b1, ca(2, 3'(4 + j)), lab[j]);
        end
        for (int j = 0; j < 4; j++) begin
            chk(ca(2, 3'(4 + j)), j == 3 ? lab[j] & acm_pkg::LABEL_LAST_MASK : lab[j]);
        end
        // All four channels at a byte a cycle exceed the line limit
        seen <= 4'hF;
        per <= 8'h01;
        // Source may stall one counter wrap, so allow three windows
        repeat (3 * WIN + 20) @(posedge mclk);
        chk(acm_pkg::OFF_SUMMARY, 32'(acm_pkg::ALM_MAJOR));
        cmp(n_s, 2);
        cmp(n_p, 4);
        // Inputs gone while old rates still stand: major beats minor
        seen <= 4'h0;
        repeat (6) @(posedge mclk);
        chk(acm_pkg::OFF_SUMMARY, 32'(acm_pkg::ALM_MAJOR));
        repeat (2 * WIN + 20) @(posedge mclk);
        cmp(n_s, 3);
        cmp(n_p, 8);
        chk(acm_pkg::OFF_SUMMARY, 32'(acm_pkg::ALM_MINOR));
        acc(1'b1, acm_pkg::OFF_RESET, acm_pkg::RESET_CMD);
        repeat (3) @(posedge mclk);
        cmp(n_r, 1);
        chk(acm_pkg::OFF_CAP, 32'(acm_pkg::CODE_OFF));
        chk(ca(1, acm_pkg::SUB_CEIL), 32'(acm_pkg::CEIL_RST));
        end_sim();
    end
endmodule // asi_channel_monitor_alarm_mgmt_bench
